// ---- include/gated_timer_pkg.sv ----
// How it works
// - one 16-bit counter works as a timer, a synchronized counter or an asynchronous counter.
// - an interrupt event is raised on a period match, or on the gate's falling edge when gated.
// - the timer can keep running in idle and in sleep, sleep needing the external clock.
// - setting run_enable (bit 15) starts counting and clearing it stops counting.
// - prescale_select (bits 5-4) divides by 256, 64, 8 or 1 for codes 11, 10, 01, 00.
// - clock_source_select (bit 1) picks the external pin's rising edge or the internal clock.
// - gated_accumulate (bit 6) is ignored on the external clock; else counts only while gate high.
// - on the external clock, ext_clock_sync (bit 2) picks synchronized or unsynchronized counting.
// - unimplemented control bits 14, 12-7, 3 and 0 read as zero.
package gated_timer_pkg;
	localparam logic [11:0] ADDR_CONTROL = 12'h000;
	localparam logic [11:0] ADDR_PERIOD = 12'h004;
	localparam logic [11:0] ADDR_COUNT = 12'h008;
	localparam logic [11:0] ADDR_IRQ_STATUS = 12'h00C;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;
	localparam logic [11:0] ADDR_IRQ_PRIORITY = 12'h014;
	localparam int BIT_RUN = 15;
	localparam int BIT_IDLE_STOP = 13;
	localparam int BIT_GATE = 6;
	localparam int BIT_PS_HI = 5;
	localparam int BIT_PS_LO = 4;
	localparam int BIT_SYNC = 2;
	localparam int BIT_CS = 1;
	localparam logic [15:0] CONTROL_WMASK = 16'hA076;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
	localparam int IRQ_MATCH = 0;
	localparam int IRQ_GATE = 1;
	localparam int IRQ_BITS = 2;
	localparam logic [7:0] DIV_8 = 8'h07;
	localparam logic [7:0] DIV_64 = 8'h3F;
	localparam logic [7:0] DIV_256 = 8'hFF;
endpackage : gated_timer_pkg

// ---- rtl/gated_timer.sv ----
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module gated_timer #(
	parameter int WIDTH = 16
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic external_clock_pin,
	input wire logic cpu_idle,
	input wire logic cpu_sleep,
	output logic irq,
	output logic [2:0] irq_priority
);
	import gated_timer_pkg::*;

	// ************************************************************
	// elaboration check
	// ************************************************************
	if (WIDTH != 16) begin : g_width_check
		$error("gated_timer only supports a 16-bit counter");
	end

	logic [15:0] control_q;
	logic [WIDTH-1:0] period_q;
	logic [WIDTH-1:0] count_q;
	logic [IRQ_BITS-1:0] status_q;
	logic [IRQ_BITS-1:0] mask_q;
	logic [2:0] prio_q;
	logic [7:0] pre_q;
	logic pin_s1_q;
	logic pin_s2_q;
	logic pin_s3_q;
	logic pin_raw_q;
	logic match_pend_q;

	// ************************************************************
	// apb decode
	// ************************************************************
	function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
		return a == r;
	endfunction : hit

	logic wr_en;
	logic rd_en;
	// a write lands only at the edge where the master sees pready high
	assign wr_en = psel && penable && pwrite && pready;
	assign rd_en = psel && penable && !pwrite;

	// control register, reset clears all bits
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			control_q <= CONTROL_RESET;
		end else if (wr_en && hit(paddr, ADDR_CONTROL)) begin
			control_q <= pwdata[15:0] & CONTROL_WMASK;
		end
	end

	// period, mask and priority
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			period_q <= PERIOD_RESET;
			mask_q <= '0;
			prio_q <= 3'h0;
		end else if (wr_en) begin
			if (hit(paddr, ADDR_PERIOD)) begin
				period_q <= pwdata[WIDTH-1:0];
			end
			if (hit(paddr, ADDR_IRQ_MASK)) begin
				mask_q <= pwdata[IRQ_BITS-1:0];
			end
			if (hit(paddr, ADDR_IRQ_PRIORITY)) begin
				prio_q <= pwdata[2:0];
			end
		end
	end

	// ************************************************************
	// clock selection
	// ************************************************************
	// the pin is treated as synchronous; the three-stage path models the
	// synchronizer latency, the raw path takes the pin two cycles earlier
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			pin_s3_q <= 1'b0;
			pin_raw_q <= 1'b0;
		end else begin
			pin_s1_q <= external_clock_pin;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_raw_q <= external_clock_pin;
		end
	end

	logic ext_sel;
	logic ext_rise_sync;
	logic ext_rise_async;
	logic ext_rise;
	logic gate_level;
	logic gate_fall;
	logic gated_mode;
	logic halted;
	logic tick_in;
	logic tick;
	logic [7:0] div_top;

	assign ext_sel = control_q[BIT_CS];
	assign ext_rise_sync = pin_s2_q && !pin_s3_q;
	assign ext_rise_async = external_clock_pin && !pin_raw_q;
	assign ext_rise = control_q[BIT_SYNC] ? ext_rise_sync : ext_rise_async;
	assign gate_level = pin_s2_q;
	assign gate_fall = !pin_s2_q && pin_s3_q;
	assign gated_mode = !ext_sel && control_q[BIT_GATE];
	// sleep stops the core clock, so only the external source may advance
	assign halted = !control_q[BIT_RUN]
		|| (cpu_idle && control_q[BIT_IDLE_STOP])
		|| (cpu_sleep && !ext_sel);
	always_comb begin
		if (ext_sel) begin
			tick_in = ext_rise;
		end else if (gated_mode) begin
			tick_in = gate_level;
		end else begin
			tick_in = 1'b1;
		end
	end

	// prescaler ratio decode
	always_comb begin
		case (control_q[BIT_PS_HI:BIT_PS_LO])
			2'b11: div_top = DIV_256;
			2'b10: div_top = DIV_64;
			2'b01: div_top = DIV_8;
			default: div_top = 8'h00;
		endcase
	end

	// prescaler, cleared when the timer is stopped
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pre_q <= 8'h00;
		end else if (!control_q[BIT_RUN]) begin
			pre_q <= 8'h00;
		end else if (!halted && tick_in) begin
			pre_q <= (pre_q >= div_top) ? 8'h00 : pre_q + 8'h01;
		end
	end
	assign tick = !halted && tick_in && (pre_q >= div_top);

	// ************************************************************
	// counter
	// ************************************************************
	logic match;
	assign match = count_q == period_q;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			count_q <= '0;
			match_pend_q <= 1'b0;
		end else if (wr_en && hit(paddr, ADDR_COUNT)) begin
			count_q <= pwdata[WIDTH-1:0];
			match_pend_q <= 1'b0;
		end else if (tick) begin
			if (match) begin
				count_q <= '0;
			end else begin
				count_q <= count_q + 1'b1;
			end
			match_pend_q <= 1'b0;
		end else if (match && !halted) begin
			match_pend_q <= 1'b1;
		end
	end

	// ************************************************************
	// interrupts
	// ************************************************************
	logic [IRQ_BITS-1:0] ev;
	logic match_ev;
	// one event per match: raised on the counting edge that wraps
	assign match_ev = tick && match;
	assign ev[IRQ_MATCH] = match_ev && !gated_mode;
	assign ev[IRQ_GATE] = gate_fall && gated_mode && !halted;

	// sticky status, set beats a write-one clear
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			status_q <= '0;
		end else begin
			if (wr_en && hit(paddr, ADDR_IRQ_STATUS)) begin
				status_q <= (status_q & ~pwdata[IRQ_BITS-1:0]) | ev;
			end else begin
				status_q <= status_q | ev;
			end
		end
	end

	// irq lags status by one cycle so it comes from a flop
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
			irq_priority <= 3'h0;
		end else begin
			irq <= |(status_q & mask_q);
			irq_priority <= prio_q;
		end
	end

	// ************************************************************
	// apb read and response
	// ************************************************************
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			ADDR_CONTROL: rd_mux = {16'h0000, control_q};
			ADDR_PERIOD: rd_mux = {16'h0000, period_q};
			ADDR_COUNT: rd_mux = {16'h0000, count_q};
			ADDR_IRQ_STATUS: rd_mux = {30'h0000_0000, status_q};
			ADDR_IRQ_MASK: rd_mux = {30'h0000_0000, mask_q};
			ADDR_IRQ_PRIORITY: rd_mux = {29'h0000_0000, prio_q};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	logic unmapped;
	assign unmapped = paddr[1:0] != 2'b00 || paddr > ADDR_IRQ_PRIORITY;

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			prdata <= rd_en ? rd_mux : 32'h0000_0000;
			pslverr <= unmapped;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	logic unused;
	assign unused = match_pend_q ^ (|pwdata[31:16]);
endmodule : gated_timer
`default_nettype wire

// ---- tb/ext_pin_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****
// far side: clock or gate level on the pin
// ****
module ext_pin_model (
	input wire logic core_clk,
	input wire logic en,
	input wire logic gate_mode,
	output logic pin
);
	logic [1:0] cnt_q = 2'h0;
	logic tog_q = 1'b0;
	// clock stands low outside a burst, so stale edges never count
	always_ff @(posedge core_clk) begin
		cnt_q <= en ? cnt_q + 2'h1 : 2'h0;
		if (!en) tog_q <= 1'b0;
		else if (cnt_q == 2'h3) tog_q <= ~tog_q;
	end
	assign pin = gate_mode ? en : tog_q;
endmodule : ext_pin_model
`default_nettype wire

// ---- tb/gated_timer_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****
// bus and read-back checks
// ****
module gated_timer_assertions
	import gated_timer_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// finished access and refused address
	wire acc = psel && penable && pready;
	wire bad = paddr > ADDR_IRQ_PRIORITY || paddr[1:0] != 2'h0;
	a_ready_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("late pready");
	a_ready_pulse: assert property (pready |=> !pready) else $error("long pready");
	a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray pready");
	a_err_bad_addr: assert property (acc && bad |-> pslverr) else $error("no pslverr");
	a_ok_good_addr: assert property (acc && !bad |-> !pslverr) else $error("false pslverr");
	a_err_read_zero: assert property (acc && pslverr && !pwrite |-> prdata == 0)
		else $error("refused read not zero");
	a_ctrl_unused_zero: assert property (
		acc && !pwrite && paddr == ADDR_CONTROL |-> (prdata & ~{16'h0, CONTROL_WMASK}) == 0)
		else $error("unused bit set");
	a_upper_half_zero: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0)
		else $error("upper half set");
	a_reset_quiet: assert property ($rose(rst_b) |-> !irq && !pready)
		else $error("busy after reset");
	cover property (acc && pslverr);
	cover property ($rose(irq));
	cover property (acc && pwrite && paddr == ADDR_CONTROL);
endmodule : gated_timer_assertions
bind gated_timer gated_timer_assertions chk (.*);
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****
// self-checking bench
// ****
module testbench;
	import gated_timer_pkg::*;
	typedef struct {logic [11:0] a; logic [31:0] d, x; logic e;} row_t;
	logic core_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
	logic idle = 0, slp = 0, en = 0, gm = 0, pready, pslverr, irq, pin, err;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [2:0] prio;
	int failures = 0, total_checks = 0, cyc = 0, lo;
	int sh [4] = '{0, 3, 6, 8};
	logic [31:0] ext [3] = '{32'h0000_8002, 32'h0000_8006, 32'h0000_8042};
	row_t rows [6] = '{'{ADDR_CONTROL, 32'hFFFF_FFFF, 32'h0000_A076, 0},
		'{ADDR_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0003, 0},
		'{ADDR_PERIOD, 32'h0001_0003, 32'h0000_0003, 0},
		'{ADDR_IRQ_PRIORITY, 32'h0000_0005, 32'h0000_0005, 0},
		'{12'h018, 32'h0000_0001, 32'h0000_0000, 1},
		'{12'h006, 32'h0000_0001, 32'h0000_0000, 1}};
	gated_timer DUT (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .external_clock_pin(pin), .cpu_idle(idle), .cpu_sleep(slp),
		.irq(irq), .irq_priority(prio));
	ext_pin_model far (.core_clk(core_clk), .en(en), .gate_mode(gm), .pin(pin));
	initial forever #10 core_clk = ~core_clk;
	// a hang ends the run as a failure
	always @(posedge core_clk) if (++cyc > 20000) begin
		failures++;
		stop_test;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		repeat (2) @(posedge core_clk);
	endtask : apb
	// count from zero with the pin enable driven to e for n cycles and off for 8 more, then stop and read the count
	task automatic run(input logic [31:0] c, input int n, input logic e);
		apb(1, ADDR_COUNT, 0);
		apb(1, ADDR_CONTROL, c);
		en <= e;
		repeat (n) @(posedge core_clk);
		en <= 0;
		repeat (8) @(posedge core_clk);
		apb(1, ADDR_CONTROL, 0);
		apb(0, ADDR_COUNT, 0);
	endtask : run
	task automatic stop_test;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : stop_test
	// main sequence
	initial begin
		repeat (10) @(posedge core_clk);
		rst_b <= 1;
		@(posedge core_clk);
		apb(0, ADDR_CONTROL, 0);
		check(rd, {16'h0, CONTROL_RESET});
		apb(0, ADDR_PERIOD, 0);
		check(rd, {16'h0, PERIOD_RESET});
		foreach (rows[i]) begin
			apb(1, rows[i].a, rows[i].d);
			apb(0, rows[i].a, 0);
			check(rd, rows[i].x);
			check(err, rows[i].e);
		end
		check(prio, 3'h5);
		apb(1, ADDR_IRQ_STATUS, 32'h0000_0003);
		run(32'h0000_8000, 40, 0);
		check(rd <= 3, 1);
		check(irq, 1);
		apb(1, ADDR_IRQ_MASK, 0);
		check(irq, 0);
		apb(1, ADDR_IRQ_MASK, 32'h0000_0003);
		check(irq, 1);
		apb(1, ADDR_IRQ_STATUS, 32'h0000_0003);
		check(irq, 0);
		apb(1, ADDR_PERIOD, 32'h0000_FFFF);
		for (int i = 0; i < 4; i++) begin
			run(32'h0000_8000 | (i << 4), 1024, 0);
			lo = 1034 >> sh[i];
			check(rd >= lo && rd <= lo + 4, 1);
		end
		idle <= 1;
		run(32'h0000_A000, 200, 0);
		check(rd, 0);
		run(32'h0000_8000, 200, 0);
		check(rd >= 210 && rd <= 214, 1);
		idle <= 0;
		slp <= 1;
		foreach (ext[i]) begin
			run(ext[i], 82, 1);
			check(rd, 10);
		end
		apb(0, ADDR_IRQ_STATUS, 0);
		check(rd, 0);
		slp <= 0;
		gm <= 1;
		run(32'h0000_8040, 40, 1);
		check(rd >= 38 && rd <= 42, 1);
		apb(0, ADDR_IRQ_STATUS, 0);
		check(rd, 2);
		check(irq, 1);
		stop_test;
	end
endmodule : testbench
`default_nettype wire
